/* adc_ctrl_pkg.sv */
// Purpose: shared constants and carrier types for the converter control block
// Assumes: 32-bit APB register bus, one clock domain
// Notes:   offsets are byte addresses, each register one aligned word
package adc_ctrl_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_TWO_OFFSET   = 8'h00;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h08;
  localparam logic [7:0] CORE_STATE_OFFSET = 8'h0C;

  // control register field positions
  localparam int REF_SEL_LSB    = 13;
  localparam int REF_SEL_W      = 3;
  localparam int RESERVED_BIT   = 12;
  localparam int SCAN_BIT       = 10;
  localparam int FILL_BIT       = 7;
  localparam int INTERVAL_LSB   = 2;
  localparam int INTERVAL_W     = 4;
  localparam int SPLIT_BIT      = 1;
  localparam int ALT_BIT        = 0;

  // core state register field positions
  localparam int STATE_IDX_LSB  = 0;
  localparam int STATE_FILL_BIT = 4;
  localparam int STATE_MUXB_BIT = 5;

  // interrupt status and mask layout
  localparam int IRQ_INTERVAL_BIT = 0;

  // reference selection codes
  localparam logic [2:0] REF_SUPPLY_GND  = 3'h0;
  localparam logic [2:0] REF_EXTP_GND    = 3'h1;
  localparam logic [2:0] REF_SUPPLY_EXTN = 3'h2;
  localparam logic [2:0] REF_EXT_BOTH    = 3'h3;

  // result buffer word indices
  localparam logic [3:0] FIRST_WORD      = 4'h0;
  localparam logic [3:0] LOWER_LAST_WORD = 4'h7;
  localparam logic [3:0] UPPER_BASE_WORD = 4'h8;
  localparam logic [3:0] LAST_WORD       = 4'hF;

  // reset values
  localparam logic [2:0] REF_SEL_RESET  = 3'h0;
  localparam logic [3:0] INTERVAL_RESET = 4'h0;
  localparam logic       CTRL_BIT_RESET = 1'b0;
  localparam logic       MASK_RESET     = 1'b0;

  // commands towards the converter core
  typedef struct packed {
    logic       ref_upper_ext;  // upper reference from external positive pin
    logic       ref_lower_ext;  // lower reference from external negative pin
    logic       scan_enable;    // scan inputs of the first multiplexer
    logic       scan_step;      // advance scan pointer, one-cycle pulse
    logic       use_mux_b;      // next sample uses the second multiplexer
    logic       split_mode;     // buffer in two halves
    logic       fill_half;      // half currently being filled
    logic [3:0] word_idx;       // buffer word the next result goes to
  } core_cmd_t;

  // events from the converter core
  typedef struct packed {
    logic sample_done;    // one conversion result written
    logic sequence_done;  // one sample/convert sequence complete
  } core_evt_t;

endpackage : adc_ctrl_pkg

/* seq_interval_counter.sv */
// Purpose: counts completed sequences and flags the end of each interval
// Assumes: seq_done is a one-cycle pulse on pclk
// Notes:   interval_done is combinational, asserted with the closing pulse
module seq_interval_counter #(
  parameter int CNT_W = 4
) (
  input  wire logic             pclk,          // system clock
  input  wire logic             presetn,       // async reset, active low
  input  wire logic             seq_done,      // sequence complete pulse
  input  wire logic [CNT_W-1:0] interval,      // sequences per interval minus one
  input  wire logic             restart,       // clear the count
  output logic                  interval_done  // interval closes this cycle
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] count;
  } cnt_state_t;

  cnt_state_t s;
  cnt_state_t next_s;
  logic       hit;

  // refuse widths the counter cannot serve
  if (CNT_W < 1)
  begin : g_bad_width
    $error("seq_interval_counter needs CNT_W of at least 1");
  end

  // count up to the interval value, then wrap
  always_comb
  begin
    next_s = s;
    hit = seq_done && (s.count == interval);
    if (restart)
    begin
      next_s.count = '0;
    end
    else if (hit)
    begin
      next_s.count = '0;
    end
    else if (seq_done)
    begin
      next_s.count = CNT_W'(s.count + 1'b1);
    end
    interval_done = hit && !restart;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule : seq_interval_counter

/* adc_sequence_buffer_control.sv */
// Purpose: second converter control register, buffer fill and mux sequencing
// Assumes: APB slave, core events are pulses on pclk, irq is a level
// Notes:   a ctrl write restarts the interval and the buffer position
// Notes on behaviour
// - reference field in bits 15..13 picks refs
// - codes 0..3 decode, 1xx acts as 000
// - bits 11, 9, 8, 6 read zero
// - scan bit set scans first mux inputs
// - fill bit shows half being filled, split only
// - interrupt every interval field plus one sequences
// - split bit gives two halves, else sixteen words
// - alternate bit: first A, then B, A, ...
module adc_sequence_buffer_control (
  input  wire logic                   pclk,     // system clock, 100 MHz
  input  wire logic                   presetn,  // async reset, active low
  input  wire logic                   psel,     // APB select
  input  wire logic                   penable,  // APB access phase
  input  wire logic                   pwrite,   // APB write
  input  wire logic [7:0]             paddr,    // APB byte address
  input  wire logic [31:0]            pwdata,   // APB write data
  output logic      [31:0]            prdata,   // APB read data
  output logic                        pready,   // APB ready
  output logic                        pslverr,  // APB error, unmapped address
  input  wire adc_ctrl_pkg::core_evt_t core_evt, // events from converter core
  output adc_ctrl_pkg::core_cmd_t     core_cmd, // commands to converter core
  output logic                        irq       // conversion interrupt level
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    logic [2:0]  ref_sel;
    logic        scan_en;
    logic [3:0]  interval;
    logic        split;
    logic        alt;
    logic        fill_half;
    logic [3:0]  word_idx;
    logic        mux_b;
    logic        irq_status;
    logic        irq_mask;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
    core_cmd_t   cmd;
  } state_t;

  state_t s;
  state_t next_s;
  logic   access;
  logic   commit;
  logic   wr_ctrl;
  logic   wr_status;
  logic   wr_mask;
  logic   interval_done;

  // bus phase decode
  assign access    = psel && penable;
  assign commit    = access && s.pready && pwrite;
  assign wr_ctrl   = commit && (paddr == CTRL_TWO_OFFSET);
  assign wr_status = commit && (paddr == IRQ_STATUS_OFFSET);
  assign wr_mask   = commit && (paddr == IRQ_MASK_OFFSET);

  // interval counter, restarted by any ctrl write
  seq_interval_counter #(
    .CNT_W         (INTERVAL_W)
  ) u_interval (
    .pclk          (pclk),
    .presetn       (presetn),
    .seq_done      (core_evt.sequence_done),
    .interval      (s.interval),
    .restart       (wr_ctrl),
    .interval_done (interval_done)
  );

  // next state: bus, register file, buffer and mux sequencing
  always_comb
  begin
    logic [31:0] rd_val;
    logic        hit;
    logic [3:0]  last;
    logic [3:0]  base;
    rd_val = '0;
    hit    = 1'b1;
    last   = LAST_WORD;
    base   = FIRST_WORD;
    next_s = s;

    // read value; unimplemented and reserved bits stay zero
    unique case (paddr)
      CTRL_TWO_OFFSET:
      begin
        rd_val[REF_SEL_LSB +: REF_SEL_W]   = s.ref_sel;
        rd_val[SCAN_BIT]                   = s.scan_en;
        rd_val[FILL_BIT]                   = s.split && s.fill_half;
        rd_val[INTERVAL_LSB +: INTERVAL_W] = s.interval;
        rd_val[SPLIT_BIT]                  = s.split;
        rd_val[ALT_BIT]                    = s.alt;
      end
      IRQ_STATUS_OFFSET: rd_val[IRQ_INTERVAL_BIT] = s.irq_status;
      IRQ_MASK_OFFSET:   rd_val[IRQ_INTERVAL_BIT] = s.irq_mask;
      CORE_STATE_OFFSET:
      begin
        rd_val[STATE_IDX_LSB +: 4] = s.word_idx;
        rd_val[STATE_FILL_BIT]     = s.fill_half;
        rd_val[STATE_MUXB_BIT]     = s.mux_b;
      end
      default: hit = 1'b0;
    endcase

    // one wait state: ready in the second access cycle
    next_s.pready  = access && !s.pready;
    next_s.pslverr = access && !s.pready && !hit;
    next_s.prdata  = (access && !s.pready && !pwrite) ? rd_val : '0;

    // buffer region for word advance
    // half or whole buffer
    if (s.split)
    begin
      last = s.fill_half ? LAST_WORD : LOWER_LAST_WORD;
      base = s.fill_half ? UPPER_BASE_WORD : FIRST_WORD;
    end

    // each result moves to the next word, wrapping within the region
    if (core_evt.sample_done)
    begin
      next_s.word_idx = (s.word_idx == last) ? base : 4'(s.word_idx + 4'h1);
      next_s.mux_b = s.alt && !s.mux_b;
    end

    // interval end: new half in split mode, sequence restarts on mux A
    if (interval_done)
    begin
      next_s.mux_b = 1'b0;
      if (s.split)
      begin
        next_s.fill_half = !s.fill_half;
        next_s.word_idx  = s.fill_half ? FIRST_WORD : UPPER_BASE_WORD;
      end
      else
      begin
        next_s.word_idx = FIRST_WORD;
      end
    end

    // control register write; bit 12 is not stored
    // reference field store
    if (wr_ctrl)
    begin
      next_s.ref_sel   = pwdata[REF_SEL_LSB +: REF_SEL_W];
      next_s.scan_en   = pwdata[SCAN_BIT];
      next_s.interval  = pwdata[INTERVAL_LSB +: INTERVAL_W];
      next_s.split     = pwdata[SPLIT_BIT];
      next_s.alt       = pwdata[ALT_BIT];
      next_s.fill_half = 1'b0;
      next_s.word_idx  = FIRST_WORD;
      next_s.mux_b     = 1'b0;
    end

    // sticky status: write one to clear, a new event wins
    // interval interrupt flag
    if (wr_status && pwdata[IRQ_INTERVAL_BIT])
    begin
      next_s.irq_status = 1'b0;
    end
    if (interval_done)
    begin
      next_s.irq_status = 1'b1;
    end
    if (wr_mask)
    begin
      next_s.irq_mask = pwdata[IRQ_INTERVAL_BIT];
    end
    next_s.irq = next_s.irq_status && next_s.irq_mask;

    // commands to the core, all registered
    // reference decode
    next_s.cmd.ref_upper_ext = (next_s.ref_sel == REF_EXTP_GND) ||
                               (next_s.ref_sel == REF_EXT_BOTH);
    next_s.cmd.ref_lower_ext = (next_s.ref_sel == REF_SUPPLY_EXTN) ||
                               (next_s.ref_sel == REF_EXT_BOTH);
    next_s.cmd.scan_enable = next_s.scan_en;
    next_s.cmd.scan_step   = core_evt.sample_done && s.scan_en && !s.mux_b;
    next_s.cmd.use_mux_b   = next_s.mux_b;
    next_s.cmd.split_mode  = next_s.split;
    next_s.cmd.fill_half   = next_s.fill_half;
    next_s.cmd.word_idx    = next_s.word_idx;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s            <= '0;
      s.ref_sel    <= REF_SEL_RESET;
      s.interval   <= INTERVAL_RESET;
      s.scan_en    <= CTRL_BIT_RESET;
      s.split      <= CTRL_BIT_RESET;
      s.alt        <= CTRL_BIT_RESET;
      s.irq_mask   <= MASK_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign prdata   = s.prdata;
  assign pready   = s.pready;
  assign pslverr  = s.pslverr;
  assign core_cmd = s.cmd;
  assign irq      = s.irq;

  // sequences counted since the last interval end, for checking only
  logic [4:0] seq_seen;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_seen <= 5'h00;
    end
    else if (wr_ctrl || interval_done)
    begin
      seq_seen <= 5'h00;
    end
    else if (core_evt.sequence_done)
    begin
      seq_seen <= 5'(seq_seen + 5'h01);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence ctrl_write_s;
    wr_ctrl;
  endsequence

  sequence interval_end_s;
    interval_done && !wr_ctrl;
  endsequence

  sequence plain_sample_s;
    core_evt.sample_done && !interval_done && !wr_ctrl;
  endsequence

  ref_field_a: assert property (ctrl_write_s |=>
    s.ref_sel == $past(pwdata[15:13]))
    else $error("reference field not stored from write");

  ref_decode_a: assert property (ctrl_write_s |=>
    (core_cmd.ref_upper_ext == ($past(pwdata[15:13]) inside {3'h1, 3'h3})) &&
    (core_cmd.ref_lower_ext == ($past(pwdata[15:13]) inside {3'h2, 3'h3})))
    else $error("reference outputs mismatch written code");

  unimpl_zero_a: assert property (
    (pready && !pwrite && !pslverr && $past(paddr) == CTRL_TWO_OFFSET)
    |-> (prdata[12:11] == 2'h0) && (prdata[9:8] == 2'h0) && !prdata[6])
    else $error("unimplemented control bits read nonzero");

  scan_step_a: assert property (core_cmd.scan_step |->
    $past(s.scan_en) && $past(core_evt.sample_done) && !$past(s.mux_b))
    else $error("scan step without scan enable");

  fill_read_a: assert property (
    (pready && !pwrite && !pslverr && $past(paddr) == CTRL_TWO_OFFSET)
    |-> prdata[7] == ($past(s.split) && $past(s.fill_half)))
    else $error("fill status readback wrong");

  interval_count_a: assert property (interval_done |->
    core_evt.sequence_done && seq_seen == {1'b0, s.interval})
    else $error("interrupt not after interval plus one sequences");

  irq_level_a: assert property (interval_end_s ##1 s.irq_mask |->
    irq)
    else $error("unmasked interval flag gives no interrupt");

  split_wrap_a: assert property (
    plain_sample_s and (s.split && !s.fill_half && s.word_idx == 4'h7)
    |=> s.word_idx == 4'h0)
    else $error("lower half does not wrap at word 7");

  whole_wrap_a: assert property (
    plain_sample_s and (!s.split && s.word_idx == 4'h7)
    |=> s.word_idx == 4'h8)
    else $error("whole buffer wraps early");

  alt_toggle_a: assert property (plain_sample_s |=>
    s.mux_b == ($past(s.alt) && !$past(s.mux_b)))
    else $error("mux alternation wrong");

  half_swap_a: assert property (interval_end_s and s.split |=>
    (s.fill_half != $past(s.fill_half)) &&
    (s.word_idx == (s.fill_half ? 4'h8 : 4'h0)))
    else $error("half not swapped at interval end");

endmodule : adc_sequence_buffer_control

/* core_model.sv */
// Purpose: converter core stand-in issuing sample and sequence events
// Assumes: events are one-cycle pulses on pclk
// Notes:   slow mode leaves an idle cycle before each sample
module core_model (
  input  wire logic                    pclk,    // system clock
  input  wire logic                    presetn, // async reset, active low
  input  wire logic                    go,      // start one sequence
  input  wire logic [3:0]              last,    // samples per sequence minus one
  input  wire logic                    slow,    // idle cycle before each sample
  output adc_ctrl_pkg::core_evt_t      evt,     // events towards the block
  output logic                         busy     // sequence in progress
);
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctrl_pkg::*;
  logic [3:0] left;
  logic       gap;

  // sequence end travels together with the final sample
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt  <= '0;
      busy <= 1'b0;
      left <= 4'h0;
      gap  <= 1'b0;
    end
    else
    begin
      evt <= '0;
      if (!busy)
      begin
        busy <= go;
        left <= last;
        gap  <= slow;
      end
      else if (gap)
        gap <= 1'b0;
      else
      begin
        evt.sample_done   <= 1'b1;
        evt.sequence_done <= (left == 4'h0);
        busy              <= (left != 4'h0);
        left              <= left - 4'h1;
        gap               <= slow;
      end
    end
  end
endmodule : core_model

/* tb_adc_sequence_buffer_control.sv */
// Purpose: self-checking bench for the converter control block
// Assumes: one-wait-state APB slave, core events synchronous to pclk
// Notes:   a reference model follows buffer word, half and mux per sample
module tb_adc_sequence_buffer_control;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctrl_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        go = 1'b0, slow = 1'b0, estat = 1'b0, mask = 1'b0;
  logic        pready, pslverr, irq, busy, err, ehalf, eb, split, alt, scan;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] wcur, w;
  logic [3:0]  last = 4'h0, eidx, n;
  core_evt_t   evt;
  core_cmd_t   cmd;
  int          error_cnt, cmp_count, scan_cnt, scan_exp, ecnt;

  // block under test and core stand-in
  adc_sequence_buffer_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_evt(evt), .core_cmd(cmd), .irq(irq));
  core_model core (.pclk(pclk), .presetn(presetn), .go(go), .last(last), .slow(slow),
    .evt(evt), .busy(busy));

  // clock
  always #5 pclk = ~pclk;

  // count scan advance pulses
  always @(posedge pclk)
  begin
    if (cmd.scan_step === 1'b1)
      scan_cnt++;
  end

  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one APB transfer, then one idle edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    chk(k < 20, 1'b1);
  endtask : apb

  // expected reference steering
  function automatic logic [1:0] ref_exp(input logic [2:0] c);
    return (c == REF_EXTP_GND) ? 2'b10 : (c == REF_SUPPLY_EXTN) ? 2'b01 :
           (c == REF_EXT_BOTH) ? 2'b11 : 2'b00;
  endfunction : ref_exp

  // expected control readback
  function automatic logic [31:0] ctrl_rb(input logic [15:0] v, input logic h);
    return {16'h0, v & 16'hE43F} | {24'h0, v[SPLIT_BIT] & h, 7'h0};
  endfunction : ctrl_rb

  // write control word and restart the model
  task automatic cfg(input logic [15:0] v);
    apb(1'b1, CTRL_TWO_OFFSET, {16'h0, v});
    wcur  = v;
    split = v[SPLIT_BIT];
    alt   = v[ALT_BIT];
    scan  = v[SCAN_BIT];
    n     = v[INTERVAL_LSB +: INTERVAL_W];
    eidx  = FIRST_WORD;
    ehalf = 1'b0;
    eb    = 1'b0;
    ecnt  = 0;
    chk({cmd.ref_upper_ext, cmd.ref_lower_ext}, ref_exp(v[15:13]));
    chk({cmd.scan_enable, cmd.split_mode}, {scan, split});
    apb(1'b0, CTRL_TWO_OFFSET, 32'h0);
    chk(rd, ctrl_rb(v, 1'b0));
  endtask : cfg

  // one sample/convert sequence with its expectations
  task automatic run_seq(input logic [3:0] l, input logic s);
    int k;
    last <= l;
    slow <= s;
    go   <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (int i = 0; i <= l; i++)
    begin
      if (scan && !eb)
        scan_exp++;
      if (i == l && ecnt == n)
      begin
        estat = 1'b1;
        ehalf = split & ~ehalf;
        eidx  = {ehalf, 3'h0};
        eb    = 1'b0;
      end
      else
      begin
        eidx = split ? {eidx[3], eidx[2:0] + 3'h1} : eidx + 4'h1;
        eb   = alt & ~eb;
      end
    end
    ecnt = (ecnt == n) ? 0 : ecnt + 1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (busy && k < 80);
    chk(k < 80, 1'b1);
    repeat (3) @(posedge pclk);
    chk({cmd.fill_half, cmd.use_mux_b, cmd.word_idx}, {ehalf, eb, eidx});
    chk(scan_cnt, scan_exp);
    chk(irq, estat & mask);
    apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
    chk(rd, estat);
    apb(1'b0, CTRL_TWO_OFFSET, 32'h0);
    chk(rd, ctrl_rb(wcur, ehalf));
    if (estat)
    begin
      apb(1'b1, IRQ_STATUS_OFFSET, 32'h1);
      estat = 1'b0;
      @(posedge pclk);
      chk(irq, 1'b0);
    end
  endtask : run_seq

  // counts and verdict
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // cut a hang short
  initial
  begin
    #400us;
    error_cnt++;
    conclude();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h90E5BD94));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(cmd, 32'h0);
    for (int a = 0; a < 16; a += 4)
    begin
      apb(1'b0, a[7:0], 32'h0);
      chk(rd, 32'h0);
      chk(err, 1'b0);
    end
    // unmapped address answers with an error and zero data
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    $display("reset values done");
    for (int c = 0; c < 8; c++)
    begin
      w = $urandom;
      w[15:13] = c[2:0];
      w[RESERVED_BIT] = 1'b0;
      cfg(w);
    end
    $display("reference codes done");
    for (int t = 0; t < 10; t++)
    begin
      w = $urandom;
      w[RESERVED_BIT] = 1'b0;
      if (t < 2)
        w[5:0] = (t == 0) ? 6'h03 : 6'h3E;
      mask = $urandom;
      apb(1'b1, IRQ_MASK_OFFSET, {31'h0, mask});
      apb(1'b0, IRQ_MASK_OFFSET, 32'h0);
      chk(rd, {31'h0, mask});
      cfg(w);
      repeat (2 * n + 3) run_seq($urandom, $urandom);
      $display("test %0d done", t);
    end
    // mid-run reset returns outputs and registers to their reset values
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({irq, cmd}, 32'h0);
    apb(1'b0, CTRL_TWO_OFFSET, 32'h0);
    chk(rd, 32'h0);
    $display("mid-run reset done");
    conclude();
  end
endmodule : tb_adc_sequence_buffer_control
